// >>> i2c_slave_register_access.sv
// Purpose: slave two-wire interface with select byte and register read/write
// Assumes: scl and sda_in are asynchronous pins sampled on sys_clk
// Notes: open drain output; oe low means the pin is pulled low
`timescale 1ns/100ps
`default_nettype none
module i2c_slave_register_access
    import i2c_slave_pkg::*;
#(
    parameter int REG_POR_CYCLES = REG_POR_CYC,
    parameter int PORT_POR_CYCLES = PORT_POR_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic supply_good,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic [ADDR_PINS-1:0] device_select_pins,
    input wire logic [7:0] port_status [8],
    input wire logic [7:0] adc_low,
    input wire logic [7:0] adc_high,
    input wire logic [7:0] chip_id,
    output logic [7:0] common_ctrl,
    output logic [7:0] port_ctrl [8],
    output logic port_ctrl_wr,
    output logic port_reset_n
);
    initial begin
        if (REG_POR_CYCLES < 1 || PORT_POR_CYCLES <= REG_POR_CYCLES) begin
            $error("Port delay must exceed interface delay");
        end
        if (ADDR_SEL_LSB + ADDR_PINS != ADDR_RSV_LSB || ADDR_RSV_MSB != 7) begin
            $error("Address fields do not fill one byte");
        end
        if (SEL_PORT_LSB + 3 > SEL_REG_LSB || SEL_REG_LSB + 3 > 8) begin
            $error("Select fields overlap or overflow");
        end
        if (PORT_POR_CYCLES >= 32'h7fff_ffff) begin
            $error("Power-on count exceeds the counter");
        end
    end

    typedef enum logic [5:0] {
        ST_IDLE = 6'b00_0001,
        ST_ADDR = 6'b00_0010,
        ST_SEL = 6'b00_0100,
        ST_WDATA = 6'b00_1000,
        ST_RDATA = 6'b01_0000,
        ST_ACK = 6'b10_0000
    } state_t;

    typedef enum logic [1:0] {
        NXT_SEL = 2'h0,
        NXT_WDATA = 2'h1,
        NXT_RDATA = 2'h2,
        NXT_IDLE = 2'h3
    } after_ack_t;

    typedef struct packed {
        logic [2:0] scl_sync;
        logic [2:0] sda_sync;
        logic [ADDR_PINS-1:0] pins_meta;
        logic [ADDR_PINS-1:0] pins_sync;
        logic [31:0] por_cnt;
        logic if_rst;
        logic port_rst;
        state_t state;
        after_ack_t after_ack;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic [7:0] select;
        logic have_select;
        logic ack_drive;
        logic ack_seen_rise;
        logic out_bit;
        logic [7:0] common_ctrl;
        logic [63:0] port_ctrl;
        logic port_wr;
        logic oe_n;
    } state_all_t;

    state_all_t s_reg;
    state_all_t s_next;
    logic [1:0] rst_sync;
    logic rst_int_n;
    logic scl_rise;
    logic scl_fall;
    logic scl_hi;
    logic sda_v;
    logic start_seen;
    logic stop_seen;
    logic [7:0] rd_byte;
    logic [2:0] sel_reg;
    logic [2:0] sel_port;
    logic addr_rsv_ok;
    logic addr_pins_ok;
    logic addr_match;
    logic byte_done;
    logic ack_done;
    logic wr_common;
    logic wr_port;

    // Release is synchronised so no flop leaves reset on a late edge
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_int_n = rst_sync[1];

    // Stage 0 of each pin sync is read only by stage 1
    assign scl_hi = s_reg.scl_sync[1];
    assign sda_v = s_reg.sda_sync[1];
    assign scl_rise = s_reg.scl_sync[1] && !s_reg.scl_sync[2];
    assign scl_fall = !s_reg.scl_sync[1] && s_reg.scl_sync[2];
    // Two synced samples of each pin; a single flop would race the edge
    assign start_seen = scl_hi && s_reg.scl_sync[2] && !sda_v && s_reg.sda_sync[2];
    assign stop_seen = scl_hi && s_reg.scl_sync[2] && sda_v && !s_reg.sda_sync[2];
    assign sel_reg = s_reg.select[SEL_REG_LSB +: 3];
    assign sel_port = s_reg.select[SEL_PORT_LSB +: 3];

    assign addr_rsv_ok = s_reg.shift[ADDR_RSV_MSB:ADDR_RSV_LSB] == 2'b00;
    assign addr_pins_ok = s_reg.shift[ADDR_SEL_LSB +: ADDR_PINS] == s_reg.pins_sync;
    assign addr_match = addr_rsv_ok && addr_pins_ok;
    assign byte_done = scl_fall && s_reg.bit_cnt == 4'd8;
    assign ack_done = scl_fall && s_reg.ack_seen_rise;
    // Writes to read-only selects are acked but change nothing
    assign wr_common = sel_reg == SEL_COMMON_CTRL;
    assign wr_port = sel_reg == SEL_PORT_CTRL;

    // Nothing selected yet reads as unmapped rather than stale data
    always_comb begin
        rd_byte = READ_UNMAPPED;
        if (s_reg.have_select) begin
            case (sel_reg)
                SEL_PORT_STATUS: rd_byte = port_status[sel_port];
                SEL_ADC_LOW: rd_byte = adc_low;
                SEL_ADC_HIGH: rd_byte = adc_high;
                SEL_CHIP_ID: rd_byte = chip_id;
                default: rd_byte = READ_UNMAPPED;
            endcase
        end
    end

    always_comb begin
        s_next = s_reg;
        s_next.scl_sync = {s_reg.scl_sync[1:0], scl};
        s_next.sda_sync = {s_reg.sda_sync[1:0], sda_in};
        // Straps are static, yet a slow board ramp may catch them mid-edge
        s_next.pins_meta = device_select_pins;
        s_next.pins_sync = s_reg.pins_meta;
        s_next.port_wr = 1'b0;
        // Supply loss restarts both timers
        if (!supply_good) begin
            s_next.por_cnt = '0;
            s_next.if_rst = 1'b1;
            s_next.port_rst = 1'b1;
        end else begin
            if (s_reg.por_cnt < 32'(PORT_POR_CYCLES)) begin
                s_next.por_cnt = s_reg.por_cnt + 32'd1;
            end
            s_next.if_rst = s_reg.por_cnt < 32'(REG_POR_CYCLES);
            s_next.port_rst = s_reg.por_cnt < 32'(PORT_POR_CYCLES);
        end

        // Whole interface and command registers held null
        if (s_reg.if_rst) begin
            s_next.state = ST_IDLE;
            s_next.after_ack = NXT_IDLE;
            s_next.bit_cnt = '0;
            s_next.shift = '0;
            s_next.select = '0;
            s_next.have_select = 1'b0;
            s_next.ack_drive = 1'b0;
            s_next.ack_seen_rise = 1'b0;
            s_next.out_bit = 1'b1;
            s_next.common_ctrl = CMD_NULL;
            s_next.port_ctrl = {8{CMD_NULL}};
        end else if (start_seen) begin
            // Any start restarts address collection, even mid-byte
            s_next.state = ST_ADDR;
            s_next.bit_cnt = '0;
            s_next.ack_drive = 1'b0;
            s_next.out_bit = 1'b1;
        end else if (stop_seen) begin
            // Select is kept so a later read can use it
            s_next.state = ST_IDLE;
            s_next.ack_drive = 1'b0;
            s_next.out_bit = 1'b1;
        end else begin
            case (s_reg.state)
                ST_IDLE: begin
                    // Released bus until the next start
                    s_next.out_bit = 1'b1;
                end

                ST_ADDR, ST_SEL, ST_WDATA: begin
                    // Bits are taken on the rising clock edge
                    if (scl_rise) begin
                        s_next.shift = {s_reg.shift[6:0], sda_v};
                        s_next.bit_cnt = s_reg.bit_cnt + 4'd1;
                    end else if (byte_done) begin
                        s_next.bit_cnt = '0;
                        s_next.state = ST_ACK;
                        s_next.ack_seen_rise = 1'b0;
                        s_next.ack_drive = 1'b1;
                        if (s_reg.state == ST_ADDR) begin
                            if (!addr_match) begin
                                s_next.state = ST_IDLE;
                                s_next.ack_drive = 1'b0;
                            end else if (s_reg.shift[ADDR_RW_BIT]) begin
                                s_next.after_ack = NXT_RDATA;
                            end else begin
                                s_next.after_ack = NXT_SEL;
                            end
                        end else if (s_reg.state == ST_SEL) begin
                            s_next.select = s_reg.shift;
                            s_next.have_select = 1'b1;
                            s_next.after_ack = NXT_WDATA;
                        end else begin
                            // Data is stored in the same cycle its ack goes out
                            s_next.after_ack = NXT_IDLE;
                            if (wr_common) begin
                                s_next.common_ctrl = s_reg.shift;
                            end else if (wr_port) begin
                                s_next.port_ctrl[sel_port*8 +: 8] = s_reg.shift;
                                s_next.port_wr = 1'b1;
                            end
                        end
                    end
                end

                ST_ACK: begin
                    // Ack held low through the whole ninth high phase
                    if (scl_rise) begin
                        s_next.ack_seen_rise = 1'b1;
                    end else if (ack_done) begin
                        s_next.ack_drive = 1'b0;
                        s_next.bit_cnt = '0;
                        case (s_reg.after_ack)
                            NXT_SEL: s_next.state = ST_SEL;
                            NXT_WDATA: s_next.state = ST_WDATA;
                            NXT_RDATA: begin
                                s_next.state = ST_RDATA;
                                s_next.shift = rd_byte;
                                s_next.out_bit = rd_byte[7];
                                s_next.bit_cnt = 4'd1;
                            end
                            default: s_next.state = ST_IDLE;
                        endcase
                    end
                end

                ST_RDATA: begin
                    // Master ack or nack ignored; the fall after the eighth bit closes the read
                    if (scl_fall) begin
                        if (s_reg.bit_cnt < 4'd8) begin
                            s_next.out_bit = s_reg.shift[3'(7 - s_reg.bit_cnt)];
                            s_next.bit_cnt = s_reg.bit_cnt + 4'd1;
                        end else begin
                            s_next.out_bit = 1'b1;
                            s_next.state = ST_IDLE;
                        end
                    end
                end

                default: s_next.state = ST_IDLE;
            endcase
        end

        // Pin enable follows the next state, so it leaves a flop, not a gate
        s_next.oe_n = !(s_next.ack_drive || !s_next.out_bit);
    end

    always_ff @(posedge sys_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
            s_reg.scl_sync <= 3'b111;
            s_reg.sda_sync <= 3'b111;
            s_reg.pins_meta <= '0;
            s_reg.pins_sync <= '0;
            s_reg.por_cnt <= '0;
            s_reg.if_rst <= 1'b1;
            s_reg.port_rst <= 1'b1;
            s_reg.state <= ST_IDLE;
            s_reg.after_ack <= NXT_IDLE;
            s_reg.bit_cnt <= '0;
            s_reg.shift <= '0;
            s_reg.select <= '0;
            s_reg.have_select <= 1'b0;
            s_reg.ack_drive <= 1'b0;
            s_reg.ack_seen_rise <= 1'b0;
            s_reg.out_bit <= 1'b1;
            s_reg.common_ctrl <= CMD_NULL;
            s_reg.port_ctrl <= {8{CMD_NULL}};
            s_reg.port_wr <= 1'b0;
            s_reg.oe_n <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // Low on the pin when acking or sending a zero
    assign sda_out = 1'b0;
    assign sda_oe_n = s_reg.oe_n;
    assign common_ctrl = s_reg.common_ctrl;
    assign port_ctrl_wr = s_reg.port_wr;
    assign port_reset_n = !s_reg.port_rst;

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_port
            assign port_ctrl[g] = s_reg.port_ctrl[g*8 +: 8];
        end
    endgenerate
endmodule
`default_nettype wire

// >>> i2c_slave_pkg.sv
// Purpose: shared constants for the two-wire slave register access block
// Assumes: 200 MHz system clock
// Notes: register select codes and reset values live here
package i2c_slave_pkg;
    localparam int ADDR_PINS = 5;
    localparam logic [2:0] SEL_COMMON_CTRL = 3'h0;
    localparam logic [2:0] SEL_PORT_STATUS = 3'h1;
    localparam logic [2:0] SEL_PORT_CTRL = 3'h2;
    localparam logic [2:0] SEL_ADC_LOW = 3'h3;
    localparam logic [2:0] SEL_ADC_HIGH = 3'h4;
    localparam logic [2:0] SEL_CHIP_ID = 3'h5;
    localparam int SEL_REG_LSB = 3;
    localparam int SEL_PORT_LSB = 0;
    localparam logic [7:0] CMD_NULL = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    localparam int ADDR_RSV_MSB = 7;
    localparam int ADDR_RSV_LSB = 6;
    localparam int ADDR_SEL_LSB = 1;
    localparam int ADDR_RW_BIT = 0;
    localparam int SYS_CLK_MHZ = 200;
    localparam int REG_POR_NS = 1000;
    localparam int PORT_POR_NS = 5000;
    localparam int REG_POR_CYC = (REG_POR_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int PORT_POR_CYC = (PORT_POR_NS * SYS_CLK_MHZ + 999) / 1000;
endpackage

// >>> i2c_slave_register_access_properties.sv
// Purpose: port-level assertions for the two-wire slave block
// Assumes: bus idles with clock and data high, transfers on a 32-cycle bit
// Notes: bound from the testbench top file
`timescale 1ns/100ps
`default_nettype none
module i2c_slave_register_access_properties #(
    parameter int PORT_POR_CYCLES = 10
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic supply_good,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic [7:0] common_ctrl,
    input wire logic port_ctrl_wr,
    input wire logic port_reset_n
);
    logic [15:0] good_cnt_reg;
    // Counts from the raw reset release, so it overstates the internal delay
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            good_cnt_reg <= 16'h0000;
        end else if (!supply_good) begin
            good_cnt_reg <= 16'h0000;
        end else if (good_cnt_reg != 16'hffff) begin
            good_cnt_reg <= good_cnt_reg + 16'h0001;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    AST_SDA_OUT_LOW: assert property (sda_out == 1'b0)
        else $error("open drain data output not low");
    AST_SUPPLY_RESET: assert property ($fell(supply_good) |-> ##6
        (sda_oe_n && common_ctrl == 8'h00 && !port_reset_n)) else $error("supply loss ignored");
    AST_PORT_LATE: assert property ($rose(port_reset_n) |-> good_cnt_reg >= PORT_POR_CYCLES)
        else $error("port reset released too early");
    AST_OE_SCL_LOW: assert property ($changed(sda_oe_n) |-> !scl)
        else $error("data drive changed while clock high");
    AST_ACK_HOLD: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*8])
        else $error("data drive glitch");
    AST_QUIET_STOP: assert property (scl && $past(scl) && $rose(sda_in) |-> sda_oe_n [*8])
        else $error("driving around a stop");
    AST_QUIET_START: assert property (scl && $past(scl) && $fell(sda_in) |-> sda_oe_n [*8])
        else $error("driving around a start");
    AST_WR_PULSE: assert property (port_ctrl_wr |=> !port_ctrl_wr)
        else $error("write pulse too long");
    AST_WR_ACK: assert property (port_ctrl_wr |-> ##[0:8] !sda_oe_n)
        else $error("stored byte not acknowledged");
    CV_WRITE: cover property (port_ctrl_wr);
    CV_ACK: cover property ($fell(sda_oe_n));
    CV_SUPPLY: cover property ($fell(supply_good));
endmodule
`default_nettype wire

// >>> i2c_master_model.sv
// Purpose: behavioural bus master driving clock and data toward the slave
// Assumes: data line pulled up, a quarter bit is 8 system clocks
// Notes: released data reads back high through the pull-up
`timescale 1ns/100ps
`default_nettype none
module i2c_master_model (
    input wire logic sys_clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_drv
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic q(input int n);
        repeat (8 * n) @(posedge sys_clk);
        #1;
    endtask
    task automatic start_cond();
        sda_drv = 1'b1;
        q(1);
        scl = 1'b1;
        q(1);
        sda_drv = 1'b0;
        q(1);
        scl = 1'b0;
    endtask
    task automatic stop_cond();
        sda_drv = 1'b0;
        q(1);
        scl = 1'b1;
        q(1);
        sda_drv = 1'b1;
        q(2);
    endtask
    task automatic pulse(output logic s);
        q(1);
        scl = 1'b1;
        q(1);
        s = sda_line;
        q(1);
        scl = 1'b0;
        q(1);
    endtask
    task automatic send_bits(input logic [7:0] b, input int n);
        logic s;
        for (int i = 7; i > 7 - n; i--) begin
            sda_drv = b[i];
            pulse(s);
        end
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        send_bits(b, 8);
        sda_drv = 1'b1;
        pulse(s);
        ack = !s;
    endtask
    task automatic recv_byte(output logic [7:0] d);
        logic s;
        sda_drv = 1'b1;
        for (int i = 7; i >= 0; i--) pulse(d[i]);
        pulse(s);
    endtask
    task automatic write_reg(input logic [7:0] a, s, d, output logic [2:0] k);
        start_cond();
        send_byte(a, k[2]);
        send_byte(s, k[1]);
        send_byte(d, k[0]);
        stop_cond();
    endtask
    task automatic read_reg(input logic [7:0] a, s, output logic [7:0] d,
        output logic [2:0] k);
        start_cond();
        send_byte(a, k[2]);
        send_byte(s, k[1]);
        stop_cond();
        start_cond();
        send_byte(a | 8'h01, k[0]);
        recv_byte(d);
        stop_cond();
    endtask
endmodule
`default_nettype wire

// >>> i2c_slave_register_access_tb_top.sv
// Purpose: self-checking bench for the two-wire slave register block
// Assumes: short power-on counts, seeded xorshift stimulus
// Notes: master model drives the bus, checker is bound below
`timescale 1ns/100ps
`default_nettype none
module i2c_slave_register_access_tb_top;
    import i2c_slave_pkg::*;
    logic sys_clk, rst_n, supply_good, scl, sda_drv, sda_out, sda_oe_n, port_ctrl_wr;
    logic port_reset_n, a;
    logic [4:0] pins;
    logic [7:0] port_status [8];
    logic [7:0] port_ctrl [8];
    logic [7:0] adc_low, adc_high, chip_id, common_ctrl, cc, pc, sel, d, got;
    logic [2:0] k;
    logic [31:0] seed = 32'h0000_003e;
    int miscompares = 0;
    int tests_run = 0;
    int wr_pulses = 0;
    wire logic sda_line;
    assign sda_line = sda_drv & (sda_oe_n | sda_out);
    i2c_slave_register_access #(.REG_POR_CYCLES(4), .PORT_POR_CYCLES(10))
    i2c_slave_register_access_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .supply_good(supply_good), .scl(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .device_select_pins(pins), .port_status(port_status),
        .adc_low(adc_low), .adc_high(adc_high), .chip_id(chip_id),
        .common_ctrl(common_ctrl), .port_ctrl(port_ctrl), .port_ctrl_wr(port_ctrl_wr),
        .port_reset_n(port_reset_n));
    i2c_master_model i2c_master_model_inst (.sys_clk(sys_clk), .sda_line(sda_line),
        .scl(scl), .sda_drv(sda_drv));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] exp_read(input logic [7:0] s);
        case (s[5:3])
            SEL_PORT_STATUS: return port_status[s[2:0]];
            SEL_ADC_LOW: return adc_low;
            SEL_ADC_HIGH: return adc_high;
            SEL_CHIP_ID: return chip_id;
            default: return READ_UNMAPPED;
        endcase
    endfunction
    task automatic check8(input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: byte %h, wanted %h", $time, g, e);
        end
    endtask
    task automatic check1(input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: bit %b, wanted %b", $time, g, e);
        end
    endtask
    task automatic complete_run();
        $display("tests_run %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (port_ctrl_wr === 1'b1) wr_pulses++;
    end
    initial begin
        repeat (60000) @(posedge sys_clk);
        miscompares++;
        complete_run();
    end
    initial begin
        rst_n = 1'b0;
        supply_good = 1'b1;
        pins = rnd() % 32;
        for (int i = 0; i < 8; i++) port_status[i] = rnd() % 256;
        {adc_low, adc_high, chip_id} = rnd() % (1 << 24);
        repeat (8) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        repeat (7) @(posedge sys_clk);
        check1(1'b0, port_reset_n);
        repeat (40) @(posedge sys_clk);
        check1(1'b1, port_reset_n);
        check8(CMD_NULL, common_ctrl | port_ctrl[0] | port_ctrl[7]);
        $display("test reset done");
        cc = CMD_NULL;
        // Every register code once, random port, write then read back
        for (int n = 0; n < 8; n++) begin
            sel = {2'b00, n[2:0], 3'(rnd() % 8)};
            d = rnd() % 256;
            pc = port_ctrl[sel[2:0]];
            if (n == 0) cc = d;
            if (n == 2) pc = d;
            i2c_master_model_inst.write_reg({2'b00, pins, 1'b0}, sel, d, k);
            check8(8'h07, {5'h00, k});
            check8(cc, common_ctrl);
            check8(pc, port_ctrl[sel[2:0]]);
            i2c_master_model_inst.read_reg({2'b00, pins, 1'b0}, sel, got, k);
            check8(8'h07, {5'h00, k});
            check8(exp_read(sel), got);
            $display("test register code %0d done", n);
        end
        check8(8'h01, 8'(wr_pulses));
        // Reserved bit set, then a pin mismatch: neither may be answered
        for (int n = 0; n < 2; n++) begin
            i2c_master_model_inst.start_cond();
            i2c_master_model_inst.send_byte(n ? {2'b00, ~pins, 1'b0} : {2'b01, pins, 1'b0}, a);
            i2c_master_model_inst.stop_cond();
            check1(1'b0, a);
        end
        i2c_master_model_inst.start_cond();
        i2c_master_model_inst.send_byte({2'b00, pins, 1'b0}, a);
        i2c_master_model_inst.send_bits(8'h5a, 4);
        i2c_master_model_inst.stop_cond();
        check8(cc, common_ctrl);
        i2c_master_model_inst.write_reg({2'b00, pins, 1'b0}, 8'h00, ~cc, k);
        cc = ~cc;
        check8(8'h07, {5'h00, k});
        check8(cc, common_ctrl);
        $display("test address refusal and abort done");
        supply_good = 1'b0;
        repeat (10) @(posedge sys_clk);
        check8(CMD_NULL, common_ctrl);
        check1(1'b0, port_reset_n);
        $display("test supply loss done");
        complete_run();
    end
endmodule
bind i2c_slave_register_access i2c_slave_register_access_properties
    #(.PORT_POR_CYCLES(PORT_POR_CYCLES)) i2c_slave_register_access_properties_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .supply_good(supply_good), .scl(scl),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .common_ctrl(common_ctrl),
    .port_ctrl_wr(port_ctrl_wr), .port_reset_n(port_reset_n));
`default_nettype wire
